// *** logic/soil_top.sv ***
// module: safety output interlock logic of a transponder door switch
// How it works
// RQ1: outputs low whenever actuator absent
// RQ2: each output follows its own input
// RQ3: status output mirrors actuator presence
// RQ4: falling single input flags unequal state
// RQ5: its return raises error and lock
// RQ6: rising accepted only after both low
// RQ7: stay off after removal until re-approach
// RQ8: diagnostic input used only with module
// RQ9: status output carries diagnostic data then
// RQ10: up to sixteen chained subscribers
// RQ11: link rebuilt at every power-up
// RQ12: answer serial, teach count, refresh name
// RQ13: learn first actuator, refuse others
// RQ14: evaluator checks both outputs separately
// RQ15: not ready or fault holds outputs low
`timescale 1ns/10ps
`default_nettype none

module soil_top
(
    // clock and reset
    input  wire logic       i_clk_sys,
    input  wire logic       i_reset_n,
    // actuator front end
    input  wire logic       i_actuator_seen,
    input  wire logic [7:0] i_actuator_code,
    // device condition
    input  wire logic       i_ready,
    input  wire logic       i_fault,
    // chained safety inputs
    input  wire logic       i_safety_input_one,
    input  wire logic       i_safety_input_two,
    // diagnostics
    input  wire logic       i_module_attached,
    input  wire logic       i_diag_input,
    // safety and status outputs
    output var  logic       o_safety_out_one,
    output var  logic       o_safety_out_two,
    output var  logic       o_status_diag_output,
    // indicators
    output var  logic       o_input_led_flash,
    output var  logic       o_plaus_error,
    output var  logic       o_part_lock,
    output var  logic       o_taught,
    output var  logic       o_name_refresh
);

    logic       rst_meta_r;
    logic       rst_n_r;
    logic       taught_r;
    logic [7:0] code_r;
    logic [7:0] teach_left_r;
    logic       present;
    logic       tx_bit;
    logic       refresh;
    soil_pkg::soil_pair_s in_pair;
    soil_pkg::soil_pair_s follow;
    soil_pkg::soil_diag_s diag;

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            rst_meta_r <= 1'b0;
            rst_n_r    <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_n_r    <= rst_meta_r;
        end
    end

    // ----------------------------------------------------------------
    // actuator teach-in: one code for life of power-up
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            taught_r     <= 1'b0;
            code_r       <= '0;
            teach_left_r <= soil_pkg::TEACH_BUDGET_RST;
        end
        else if (!taught_r && i_actuator_seen && teach_left_r != 8'h00) // [RQ13]
        begin
            taught_r     <= 1'b1;
            code_r       <= i_actuator_code;
            teach_left_r <= teach_left_r - 8'h01;
        end
    end

    // only the learnt actuator counts as present; presence is live, so
    // removal drops the outputs at the next clock edge [RQ7]
    assign present = taught_r && i_actuator_seen && (i_actuator_code == code_r); // [RQ13]

    assign in_pair.ch_one = i_safety_input_one;
    assign in_pair.ch_two = i_safety_input_two;

    soil_input_monitor u_mon
    (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (rst_n_r),
        .i_in      (in_pair),
        .o_follow  (follow),
        .o_diag    (diag)
    );

    // one subscriber of a chain of up to sixteen; no address is held here [RQ10]
    // link rebuilt from scratch after each reset, no stored setup [RQ11]
    soil_diag_link u_link
    (
        .i_clk_sys    (i_clk_sys),
        .i_rst_n      (rst_n_r),
        .i_enable     (i_module_attached),                              // [RQ8]
        .i_diag_input (i_diag_input),
        .o_tx_bit     (tx_bit),
        .i_teach_left (teach_left_r),
        .i_status     ({4'h0, diag.part_lock, diag.unequal, taught_r, present}),
        .o_refresh    (refresh)
    );

    // ----------------------------------------------------------------
    // safety outputs, registered
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            o_safety_out_one <= 1'b0;
            o_safety_out_two <= 1'b0;
        end
        else if (!present || !i_ready || i_fault)                       // [RQ1] [RQ7] [RQ15]
        begin
            o_safety_out_one <= 1'b0;
            o_safety_out_two <= 1'b0;
        end
        else
        begin
            o_safety_out_one <= follow.ch_one;                          // [RQ2]
            o_safety_out_two <= follow.ch_two;                          // [RQ2]
        end
    end

    // ----------------------------------------------------------------
    // status and indicators
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            o_status_diag_output <= 1'b0;
            o_input_led_flash    <= 1'b0;
            o_plaus_error        <= 1'b0;
            o_part_lock          <= 1'b0;
            o_taught             <= 1'b0;
            o_name_refresh       <= 1'b0;
        end
        else
        begin
            o_status_diag_output <= i_module_attached ? tx_bit : present; // [RQ3] [RQ9]
            o_input_led_flash    <= diag.unequal || diag.plaus_err;       // [RQ4] [RQ5]
            o_plaus_error        <= diag.plaus_err;
            o_part_lock          <= diag.part_lock;
            o_taught             <= taught_r;
            o_name_refresh       <= refresh;                              // [RQ12]
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_absent_low;
        @(posedge i_clk_sys) disable iff (!rst_n_r)
        !present |=> !o_safety_out_one && !o_safety_out_two;
    endproperty
    a_absent_low: assert property (p_absent_low) else $error("output high without actuator"); // [RQ1]

    property p_follow;
        @(posedge i_clk_sys) disable iff (!rst_n_r)
        present && i_ready && !i_fault |=> o_safety_out_one == $past(follow.ch_one)
                                          && o_safety_out_two == $past(follow.ch_two);
    endproperty
    a_follow: assert property (p_follow) else $error("output not following input"); // [RQ2]

    property p_status;
        @(posedge i_clk_sys) disable iff (!rst_n_r)
        !i_module_attached |=> o_status_diag_output == $past(present);
    endproperty
    a_status: assert property (p_status) else $error("status not presence"); // [RQ3]

    property p_removed;
        @(posedge i_clk_sys) disable iff (!rst_n_r)
        $fell(i_actuator_seen) |=> !o_safety_out_one && !o_safety_out_two;
    endproperty
    a_removed: assert property (p_removed) else $error("output on after removal"); // [RQ7]

    property p_diag_idle;
        @(posedge i_clk_sys) disable iff (!rst_n_r)
        i_module_attached && !$past(i_module_attached) |-> ##1 o_status_diag_output;
    endproperty
    a_diag_idle: assert property (p_diag_idle) else $error("link not idle high"); // [RQ9]

    property p_no_fault_out;
        @(posedge i_clk_sys) disable iff (!rst_n_r)
        (i_fault || !i_ready) |=> !o_safety_out_one && !o_safety_out_two;
    endproperty
    a_no_fault_out: assert property (p_no_fault_out) else $error("output on during fault"); // [RQ15]

    property p_one_teach;
        @(posedge i_clk_sys) disable iff (!rst_n_r)
        taught_r |=> taught_r && $stable(code_r);
    endproperty
    a_one_teach: assert property (p_one_teach) else $error("second actuator learnt"); // [RQ13]

    property p_flash;
        @(posedge i_clk_sys) disable iff (!rst_n_r)
        diag.unequal |=> o_input_led_flash;
    endproperty
    a_flash: assert property (p_flash) else $error("no flash on unequal"); // [RQ4]

    c_both_on: cover property (@(posedge i_clk_sys) disable iff (!rst_n_r)
        o_safety_out_one && o_safety_out_two);
    c_split: cover property (@(posedge i_clk_sys) disable iff (!rst_n_r)
        o_safety_out_one && !o_safety_out_two);
    c_refresh: cover property (@(posedge i_clk_sys) disable iff (!rst_n_r) o_name_refresh);

endmodule : soil_top

`default_nettype wire

// *** logic/soil_pkg.sv ***
// package: shared types and constants of the safety output interlock logic
`default_nettype none

package soil_pkg;

    // ----------------------------------------------------------------
    // diagnostic scheme
    // ----------------------------------------------------------------
    localparam int unsigned MAX_SUBSCRIBERS = 16;
    localparam logic [3:0]  ADDR_RST        = 4'h0;

    // diagnostic frame: 8 bit request code, frame bit count
    localparam int unsigned FRAME_BITS      = 8;
    localparam logic [7:0]  REQ_SERIAL      = 8'h01;
    localparam logic [7:0]  REQ_TEACH_LEFT  = 8'h02;
    localparam logic [7:0]  REQ_REFRESH     = 8'h03;
    localparam logic [7:0]  REQ_STATUS      = 8'h04;

    // bit time of the diagnostic link, in ns, and its cycle count at 40 MHz
    localparam int unsigned CLK_PERIOD_NS   = 25;
    localparam int unsigned DIAG_BIT_NS     = 1000;
    localparam int unsigned DIAG_BIT_CYC    = DIAG_BIT_NS / CLK_PERIOD_NS;

    // teach-in budget after reset and serial number (arbitrary value)
    localparam logic [7:0]  TEACH_BUDGET_RST = 8'h08;
    localparam logic [7:0]  SERIAL_NUMBER    = 8'h5A;

    // ----------------------------------------------------------------
    // input monitor states
    // ----------------------------------------------------------------
    typedef enum logic [1:0]
    {
        MON_NORMAL  = 2'b00,
        MON_UNEQUAL = 2'b01,
        MON_LOCK    = 2'b10
    } soil_mon_e;

    typedef struct packed
    {
        logic ch_one;
        logic ch_two;
    } soil_pair_s;

    typedef struct packed
    {
        logic unequal;
        logic plaus_err;
        logic part_lock;
    } soil_diag_s;

endpackage : soil_pkg

`default_nettype wire

// *** logic/soil_input_monitor.sv ***
// module: plausibility monitor for the two chained safety inputs
`timescale 1ns/10ps
`default_nettype none

module soil_input_monitor
(
    // clock and reset
    input  wire logic              i_clk_sys,
    input  wire logic              i_rst_n,
    // inputs
    input  wire soil_pkg::soil_pair_s i_in,
    // results
    output var  soil_pkg::soil_pair_s o_follow,
    output var  soil_pkg::soil_diag_s o_diag
);

    soil_pkg::soil_mon_e  state_r;
    soil_pkg::soil_pair_s prev_r;
    logic                 odd_one_r;

    // ----------------------------------------------------------------
    // history of the inputs
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
            prev_r <= '0;
        else
            prev_r <= i_in;
    end

    wire fall_one = prev_r.ch_one && !i_in.ch_one;
    wire fall_two = prev_r.ch_two && !i_in.ch_two;
    wire rise_one = !prev_r.ch_one && i_in.ch_one;
    wire rise_two = !prev_r.ch_two && i_in.ch_two;
    wire both_low = !i_in.ch_one && !i_in.ch_two;

    // ----------------------------------------------------------------
    // monitor state machine
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_r   <= soil_pkg::MON_LOCK;
            odd_one_r <= 1'b0;
        end
        else
        begin
            unique case (state_r)
                soil_pkg::MON_NORMAL:
                begin
                    if (fall_one && i_in.ch_two)                        // [RQ4]
                    begin
                        state_r   <= soil_pkg::MON_UNEQUAL;
                        odd_one_r <= 1'b0;
                    end
                    else if (fall_two && i_in.ch_one)                   // [RQ4]
                    begin
                        state_r   <= soil_pkg::MON_UNEQUAL;
                        odd_one_r <= 1'b1;
                    end
                end
                soil_pkg::MON_UNEQUAL:
                begin
                    if (both_low)
                        state_r <= soil_pkg::MON_NORMAL;
                    else if ((!odd_one_r && rise_one && i_in.ch_two) ||
                             (odd_one_r && rise_two && i_in.ch_one))     // [RQ5]
                        state_r <= soil_pkg::MON_LOCK;
                end
                soil_pkg::MON_LOCK:
                begin
                    if (both_low)                                       // [RQ6]
                        state_r <= soil_pkg::MON_NORMAL;
                end
                default:
                    state_r <= soil_pkg::MON_LOCK;
            endcase
        end
    end

    // lock holds both channels low; power-up starts locked so a rising
    // edge is only accepted after both inputs were seen low together
    always_comb
    begin
        o_follow.ch_one = (state_r != soil_pkg::MON_LOCK) && i_in.ch_one;  // [RQ6]
        o_follow.ch_two = (state_r != soil_pkg::MON_LOCK) && i_in.ch_two;  // [RQ6]
        o_diag.unequal   = (state_r == soil_pkg::MON_UNEQUAL);
        o_diag.plaus_err = (state_r == soil_pkg::MON_LOCK);
        o_diag.part_lock = (state_r == soil_pkg::MON_LOCK);
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_lock_after_return;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (state_r == soil_pkg::MON_UNEQUAL && !odd_one_r && rise_one && i_in.ch_two)
            |=> (state_r == soil_pkg::MON_LOCK);
    endproperty
    a_lock_after_return: assert property (p_lock_after_return) else $error("no lock after return"); // [RQ5]

    property p_unequal_flag;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (state_r == soil_pkg::MON_NORMAL && fall_one && i_in.ch_two) |=> o_diag.unequal;
    endproperty
    a_unequal_flag: assert property (p_unequal_flag) else $error("unequal not flagged"); // [RQ4]

    property p_leave_lock;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (state_r == soil_pkg::MON_LOCK) && !both_low |=> (state_r == soil_pkg::MON_LOCK);
    endproperty
    a_leave_lock: assert property (p_leave_lock) else $error("lock left early"); // [RQ6]

    c_lock: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        state_r == soil_pkg::MON_UNEQUAL ##1 state_r == soil_pkg::MON_LOCK);

endmodule : soil_input_monitor

`default_nettype wire

// *** logic/soil_diag_link.sv ***
// module: serial diagnostic link engine for the chained diagnostics bus
`timescale 1ns/10ps
`default_nettype none

module soil_diag_link
(
    // clock and reset
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst_n,
    // link
    input  wire logic       i_enable,
    input  wire logic       i_diag_input,
    output var  logic       o_tx_bit,
    // answers
    input  wire logic [7:0] i_teach_left,
    input  wire logic [7:0] i_status,
    output var  logic       o_refresh
);

    logic [$clog2(soil_pkg::DIAG_BIT_CYC)-1:0] bit_cnt_r;
    logic [2:0] idx_r;
    logic [7:0] rx_r;
    logic [7:0] tx_r;
    logic       prev_in_r;
    logic       rx_busy_r;
    logic       tx_busy_r;

    wire bit_tick = (bit_cnt_r == ($clog2(soil_pkg::DIAG_BIT_CYC))'(soil_pkg::DIAG_BIT_CYC - 1));

    function automatic logic [7:0] answer(input logic [7:0] req, input logic [7:0] tl, input logic [7:0] st);
        unique case (req)
            soil_pkg::REQ_SERIAL:     answer = soil_pkg::SERIAL_NUMBER;
            soil_pkg::REQ_TEACH_LEFT: answer = tl;
            default:                  answer = st;
        endcase
    endfunction : answer

    // ----------------------------------------------------------------
    // receive: start on falling edge, lsb first; answer after frame
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            bit_cnt_r <= '0;
            idx_r     <= '0;
            rx_r      <= '0;
            tx_r      <= 8'hFF;
            prev_in_r <= 1'b1;
            rx_busy_r <= 1'b0;
            tx_busy_r <= 1'b0;
            o_refresh <= 1'b0;
        end
        else
        begin
            prev_in_r <= i_diag_input;
            o_refresh <= 1'b0;
            bit_cnt_r <= (rx_busy_r || tx_busy_r) && !bit_tick ? bit_cnt_r + 1'b1 : '0;
            if (!i_enable)                                              // [RQ8]
            begin
                rx_busy_r <= 1'b0;
                tx_busy_r <= 1'b0;
                tx_r      <= 8'hFF;
            end
            else if (rx_busy_r && bit_tick)
            begin
                rx_r  <= {i_diag_input, rx_r[7:1]};
                idx_r <= idx_r + 1'b1;
                if (idx_r == 3'd7)
                begin
                    rx_busy_r <= 1'b0;
                    tx_busy_r <= 1'b1;
                    tx_r      <= answer({i_diag_input, rx_r[7:1]}, i_teach_left, i_status); // [RQ12]
                    o_refresh <= ({i_diag_input, rx_r[7:1]} == soil_pkg::REQ_REFRESH);      // [RQ12]
                end
            end
            else if (tx_busy_r && bit_tick)
            begin
                tx_r  <= {1'b1, tx_r[7:1]};
                idx_r <= idx_r + 1'b1;
                if (idx_r == 3'd7)
                    tx_busy_r <= 1'b0;
            end
            else if (!rx_busy_r && !tx_busy_r && prev_in_r && !i_diag_input)
            begin
                rx_busy_r <= 1'b1;
                idx_r     <= '0;
            end
        end
    end

    assign o_tx_bit = tx_busy_r ? tx_r[0] : 1'b1;                      // [RQ9]

endmodule : soil_diag_link

`default_nettype wire

// *** tb/soil_far_side.sv ***
// model: diagnostics module and two-channel evaluator beside the switch
`timescale 1ns/10ps
`default_nettype none

module soil_far_side
(
    // clock
    input  wire logic i_clk_sys,
    // from the switch
    input  wire logic i_out_one,
    input  wire logic i_out_two,
    input  wire logic i_status_diag_output,
    // to the switch, and the evaluator's release
    output var  logic o_diag_input,
    output wire logic o_gate_released
);
    // ----------------------------------------------------------------
    // evaluator
    // ----------------------------------------------------------------
    localparam int BIT_CYC = soil_pkg::DIAG_BIT_CYC;
    // the switch is one subscriber of a chain of up to sixteen
    localparam int CHAIN_MAX = soil_pkg::MAX_SUBSCRIBERS;

    // release only when both channels agree, a lone channel is implausible
    assign o_gate_released = i_out_one & i_out_two;

    // ----------------------------------------------------------------
    // diagnostics module
    // ----------------------------------------------------------------
    // line idles high; no setup is sent, so a fresh switch is served at once
    initial o_diag_input = 1'b1;

    // sends one request lsb first and samples the answer mid-bit
    task automatic exchange(input logic [7:0] code, output logic [7:0] reply);
        logic [7:0] got;
        got = 8'h00;
        fork
            begin
                @(negedge i_clk_sys);
                o_diag_input = 1'b0;
                repeat (BIT_CYC) @(negedge i_clk_sys);
                for (int i = 0; i < 8; i++)
                begin
                    o_diag_input = code[i];
                    repeat (BIT_CYC) @(negedge i_clk_sys);
                end
                o_diag_input = 1'b1;
            end
            begin
                @(negedge i_clk_sys);
                repeat (9 * BIT_CYC - BIT_CYC / 2) @(negedge i_clk_sys);
                for (int k = 0; k < 8; k++)
                begin
                    got[k] = i_status_diag_output;
                    repeat (BIT_CYC) @(negedge i_clk_sys);
                end
            end
        join
        repeat (2 * BIT_CYC) @(negedge i_clk_sys);
        reply = got;
    endtask : exchange

endmodule : soil_far_side
`default_nettype wire

// *** tb/test_safety_output_interlock_logic.sv ***
// testbench: directed checks of the safety output interlock logic
`timescale 1ns/10ps
`default_nettype none

module test_safety_output_interlock_logic;
    localparam logic [7:0] OWN_CODE   = 8'h3C;
    localparam logic [7:0] OTHER_CODE = 8'hC3;

    logic       clk;
    logic       rst_n;
    logic       seen;
    logic [7:0] code;
    logic       ready;
    logic       fault;
    logic       in_one;
    logic       in_two;
    logic       attached;
    wire logic  diag_in;
    wire logic  released;
    logic       out_one;
    logic       out_two;
    logic       status;
    logic       flash;
    logic       plaus;
    logic       part_lock;
    logic       taught;
    logic       name_refresh;
    logic [7:0] reply;
    int         err_count;
    int         n_checks;
    int         refresh_seen;

    soil_top dut
    (
        .i_clk_sys            (clk),
        .i_reset_n            (rst_n),
        .i_actuator_seen      (seen),
        .i_actuator_code      (code),
        .i_ready              (ready),
        .i_fault              (fault),
        .i_safety_input_one   (in_one),
        .i_safety_input_two   (in_two),
        .i_module_attached    (attached),
        .i_diag_input         (diag_in),
        .o_safety_out_one     (out_one),
        .o_safety_out_two     (out_two),
        .o_status_diag_output (status),
        .o_input_led_flash    (flash),
        .o_plaus_error        (plaus),
        .o_part_lock          (part_lock),
        .o_taught             (taught),
        .o_name_refresh       (name_refresh)
    );

    soil_far_side u_far
    (
        .i_clk_sys            (clk),
        .i_out_one            (out_one),
        .i_out_two            (out_two),
        .i_status_diag_output (status),
        .o_diag_input         (diag_in),
        .o_gate_released      (released)
    );

    // ----------------------------------------------------------------
    // clock, watchdog, pulse counter
    // ----------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // whole run needs about 4600 cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        err_count++;
        $display("ERROR at %0t: watchdog expired", $time);
        report_and_stop();
    end

    always @(posedge clk)
    begin
        if (name_refresh === 1'b1)
            refresh_seen++;
    end

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic expect_outs(input logic e1, input logic e2);
        check({6'h00, out_one, out_two}, {6'h00, e1, e2}, "safety outputs");
    endtask : expect_outs

    task automatic bit_is(input logic got, input logic exp, input string what);
        check({7'h00, got}, {7'h00, exp}, what);
    endtask : bit_is

    // inputs change at the falling edge, outputs are settled three cycles later
    task automatic apply(input logic s, input logic [7:0] c, input logic a, input logic b);
        @(negedge clk);
        seen = s;
        code = c;
        in_one = a;
        in_two = b;
        repeat (3) @(negedge clk);
    endtask : apply

    task automatic do_reset();
        rst_n = 1'b0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
    endtask : do_reset

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial
    begin
        rst_n = 1'b0;
        seen = 1'b0;
        code = 8'h00;
        ready = 1'b1;
        fault = 1'b0;
        in_one = 1'b1;
        in_two = 1'b1;
        attached = 1'b0;
        err_count = 0;
        n_checks = 0;
        refresh_seen = 0;
        do_reset();

        apply(1'b1, OWN_CODE, 1'b1, 1'b1);
        expect_outs(1'b0, 1'b0);
        bit_is(part_lock, 1'b1, "lock at start");
        bit_is(status, 1'b1, "presence");
        bit_is(taught, 1'b1, "learnt");
        apply(1'b1, OWN_CODE, 1'b0, 1'b0);
        bit_is(part_lock, 1'b0, "unlock");
        apply(1'b1, OWN_CODE, 1'b1, 1'b1);
        expect_outs(1'b1, 1'b1);
        bit_is(released, 1'b1, "evaluator");
        $display("test power_up_lock done");

        apply(1'b1, OWN_CODE, 1'b0, 1'b1);
        expect_outs(1'b0, 1'b1);
        bit_is(flash, 1'b1, "unequal");
        apply(1'b1, OWN_CODE, 1'b1, 1'b1);
        expect_outs(1'b0, 1'b0);
        bit_is(plaus, 1'b1, "plaus error");
        bit_is(part_lock, 1'b1, "lock");
        bit_is(flash, 1'b1, "flash in lock");
        apply(1'b1, OWN_CODE, 1'b1, 1'b0);
        expect_outs(1'b0, 1'b0);
        apply(1'b1, OWN_CODE, 1'b0, 1'b0);
        bit_is(part_lock, 1'b0, "lock cleared");
        apply(1'b1, OWN_CODE, 1'b1, 1'b0);
        expect_outs(1'b1, 1'b0);
        apply(1'b1, OWN_CODE, 1'b1, 1'b1);
        expect_outs(1'b1, 1'b1);
        apply(1'b1, OWN_CODE, 1'b1, 1'b0);
        expect_outs(1'b1, 1'b0);
        bit_is(flash, 1'b1, "unequal two");
        apply(1'b1, OWN_CODE, 1'b0, 1'b0);
        bit_is(flash, 1'b0, "equal again");
        apply(1'b1, OWN_CODE, 1'b1, 1'b1);
        expect_outs(1'b1, 1'b1);
        $display("test plausibility done");

        apply(1'b0, OWN_CODE, 1'b1, 1'b1);
        expect_outs(1'b0, 1'b0);
        bit_is(status, 1'b0, "absent");
        repeat (20) @(negedge clk);
        expect_outs(1'b0, 1'b0);
        apply(1'b1, OTHER_CODE, 1'b1, 1'b1);
        expect_outs(1'b0, 1'b0);
        apply(1'b1, OWN_CODE, 1'b1, 1'b1);
        expect_outs(1'b1, 1'b1);
        ready = 1'b0;
        repeat (3) @(negedge clk);
        expect_outs(1'b0, 1'b0);
        ready = 1'b1;
        fault = 1'b1;
        repeat (3) @(negedge clk);
        expect_outs(1'b0, 1'b0);
        fault = 1'b0;
        repeat (3) @(negedge clk);
        expect_outs(1'b1, 1'b1);
        $display("test actuator_condition done");

        u_far.exchange(soil_pkg::REQ_STATUS, reply);
        check(reply, 8'hFF, "no module");
        attached = 1'b1;
        repeat (3) @(negedge clk);
        u_far.exchange(soil_pkg::REQ_SERIAL, reply);
        check(reply, soil_pkg::SERIAL_NUMBER, "serial");
        u_far.exchange(soil_pkg::REQ_TEACH_LEFT, reply);
        check(reply, soil_pkg::TEACH_BUDGET_RST - 8'h01, "teach left");
        u_far.exchange(soil_pkg::REQ_REFRESH, reply);
        check(reply, 8'h03, "refresh answer");
        check(8'(refresh_seen), 8'h01, "refresh pulse");
        u_far.exchange(soil_pkg::REQ_STATUS, reply);
        check(reply, 8'h03, "status");
        $display("test diagnostics done");

        do_reset();
        apply(1'b1, OWN_CODE, 1'b0, 1'b0);
        apply(1'b1, OWN_CODE, 1'b1, 1'b1);
        expect_outs(1'b1, 1'b1);
        u_far.exchange(soil_pkg::REQ_STATUS, reply);
        check(reply, 8'h03, "after reset");
        $display("test second_reset done");
        report_and_stop();
    end

endmodule : test_safety_output_interlock_logic
`default_nettype wire
